// [src/hpcb_pkg.sv]
// Notes on behaviour
// - bits 5:4 set port three drive boost
// - bits 3:2 set port two drive boost
// - swap bit exchanges D+ and D- pins
// - swap covers upstream and downstream pairs
// - swap bits 3,2,0 used; others reserved
// - only port count reported; host numbers ports
// - remap mode presents mapped logical numbers
// - upper map nibble controls physical port two
// - codes above 0011 are illegal
// - lower map nibble controls physical port one
package hpcb_pkg;
    localparam logic [7:0] BOOST_ADDR = 8'hF0;
    localparam logic [7:0] SWAP_ADDR = 8'hF1;
    localparam logic [7:0] MAP12_ADDR = 8'hF2;
    localparam logic [7:0] BOOST_RESET = 8'h00;
    localparam logic [7:0] SWAP_RESET = 8'h00;
    localparam logic [7:0] MAP12_RESET = 8'h21;
    localparam logic [7:0] BOOST_RW_MASK = 8'h3C;
    localparam logic [7:0] SWAP_RW_MASK = 8'h0D;
    localparam int BOOST3_LSB = 4;
    localparam int BOOST2_LSB = 2;
    localparam int MAP_PORT2_LSB = 4;
    localparam int MAP_PORT1_LSB = 0;
    localparam logic [3:0] MAP_DISABLED = 4'h0;
    localparam logic [3:0] MAP_MAX_LEGAL = 4'h3;
    localparam logic [3:0] PHYS_PORT1 = 4'h1;
    localparam logic [3:0] PHYS_PORT2 = 4'h2;
    localparam int NUM_PAIRS = 4;

    typedef enum logic [1:0] {
        BOOST_NONE,
        BOOST_LOW,
        BOOST_MEDIUM,
        BOOST_HIGH
    } hpcb_boost_e;

    typedef struct packed {
        logic [7:0] boost;
        logic [7:0] swap;
        logic [7:0] map12;
    } hpcb_regs_s;

    typedef struct packed {
        logic [NUM_PAIRS-1:0] dp;
        logic [NUM_PAIRS-1:0] dm;
    } hpcb_pair_s;
endpackage

// [src/hpcb_port_config.sv]
`timescale 1ns/10ps
`default_nettype none
module hpcb_port_config (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic remap_mode_enable,
    output hpcb_pkg::hpcb_boost_e port_three_drive_level,
    output hpcb_pkg::hpcb_boost_e port_two_drive_level,
    output logic [3:0] pair_pin_swap_bits,
    output logic [3:0] port_one_logical,
    output logic [3:0] port_two_logical,
    output logic [1:0] downstream_port_count,
    input wire hpcb_pkg::hpcb_pair_s func_out,
    input wire logic [3:0] func_oe,
    output hpcb_pkg::hpcb_pair_s pin_out,
    output logic [3:0] pin_oe,
    input wire hpcb_pkg::hpcb_pair_s pin_in,
    output hpcb_pkg::hpcb_pair_s func_in
);
    typedef struct packed {
        hpcb_pkg::hpcb_regs_s regs;
        logic [7:0] rdata;
        hpcb_pkg::hpcb_pair_s sync1;
        hpcb_pkg::hpcb_pair_s sync2;
        hpcb_pkg::hpcb_pair_s rx;
    } hpcb_state_s;

    hpcb_state_s st_reg;
    hpcb_state_s st_next;

    ////////////////////////////////////////////////////////////////////////
    // illegal codes fall back to disabled so a bad byte never aliases a port
    function automatic logic [3:0] map_decode(input logic [3:0] code);
        map_decode = (code > hpcb_pkg::MAP_MAX_LEGAL) ? hpcb_pkg::MAP_DISABLED : code;
    endfunction

    logic [3:0] code_p1;
    logic [3:0] code_p2;

    always_comb begin
        code_p1 = st_reg.regs.map12[hpcb_pkg::MAP_PORT1_LSB +: 4];
        code_p2 = st_reg.regs.map12[hpcb_pkg::MAP_PORT2_LSB +: 4];
        if (remap_mode_enable) begin
            port_one_logical = map_decode(code_p1);
            port_two_logical = map_decode(code_p2);
        end else begin
            port_one_logical = hpcb_pkg::PHYS_PORT1;
            port_two_logical = hpcb_pkg::PHYS_PORT2;
        end
        // the hub only tells the host how many ports are live
        downstream_port_count = {1'b0, port_one_logical != hpcb_pkg::MAP_DISABLED}
            + {1'b0, port_two_logical != hpcb_pkg::MAP_DISABLED};
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.sync1 = pin_in;
        st_next.sync2 = st_reg.sync1;
        // receive path: swap decided after synchronising, never on sync1
        for (int i = 0; i < hpcb_pkg::NUM_PAIRS; i++) begin
            st_next.rx.dp[i] = pair_pin_swap_bits[i] ? st_reg.sync2.dm[i] : st_reg.sync2.dp[i];
            st_next.rx.dm[i] = pair_pin_swap_bits[i] ? st_reg.sync2.dp[i] : st_reg.sync2.dm[i];
        end
        if (cfg_wr) begin
            case (cfg_addr)
                // reserved bits are not stored and so read back zero
                hpcb_pkg::BOOST_ADDR: st_next.regs.boost = cfg_wdata & hpcb_pkg::BOOST_RW_MASK;
                hpcb_pkg::SWAP_ADDR: st_next.regs.swap = cfg_wdata & hpcb_pkg::SWAP_RW_MASK;
                // map byte kept whole; illegal codes are filtered at decode
                hpcb_pkg::MAP12_ADDR: st_next.regs.map12 = cfg_wdata;
                default: st_next.regs = st_reg.regs;
            endcase
        end
        // read data registered; it holds until the next read strobe
        if (cfg_rd) begin
            case (cfg_addr)
                hpcb_pkg::BOOST_ADDR: st_next.rdata = st_reg.regs.boost;
                hpcb_pkg::SWAP_ADDR: st_next.rdata = st_reg.regs.swap;
                hpcb_pkg::MAP12_ADDR: st_next.rdata = st_reg.regs.map12;
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg.regs.boost <= hpcb_pkg::BOOST_RESET;
            st_reg.regs.swap <= hpcb_pkg::SWAP_RESET;
            st_reg.regs.map12 <= hpcb_pkg::MAP12_RESET;
            st_reg.rdata <= 8'h00;
            st_reg.sync1 <= '0;
            st_reg.sync2 <= '0;
            st_reg.rx <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // boost is reset to no-boost; raising it is left to software
    assign port_three_drive_level =
        hpcb_pkg::hpcb_boost_e'(st_reg.regs.boost[hpcb_pkg::BOOST3_LSB +: 2]);
    assign port_two_drive_level =
        hpcb_pkg::hpcb_boost_e'(st_reg.regs.boost[hpcb_pkg::BOOST2_LSB +: 2]);
    assign pair_pin_swap_bits = st_reg.regs.swap[3:0];
    assign cfg_rdata = st_reg.rdata;
    assign func_in = st_reg.rx;
    assign pin_oe = func_oe;

    // pair 0 is upstream, pairs 2 and 3 downstream, pair 1 never swaps
    always_comb begin
        for (int i = 0; i < hpcb_pkg::NUM_PAIRS; i++) begin
            pin_out.dp[i] = pair_pin_swap_bits[i] ? func_out.dm[i] : func_out.dp[i];
            pin_out.dm[i] = pair_pin_swap_bits[i] ? func_out.dp[i] : func_out.dm[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_BOOST3_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && cfg_addr == hpcb_pkg::BOOST_ADDR |=>
        port_three_drive_level == $past(cfg_wdata[5:4]))
        else $error("port three boost not taken from write");

    AST_BOOST2_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && cfg_addr == hpcb_pkg::BOOST_ADDR |=>
        port_two_drive_level == $past(cfg_wdata[3:2]))
        else $error("port two boost not taken from write");

    AST_SWAP_RESERVED: assert property (@(posedge clk) disable iff (!resetn)
        cfg_rd && cfg_addr == hpcb_pkg::SWAP_ADDR |=> cfg_rdata[7:4] == 4'h0 && !cfg_rdata[1])
        else $error("reserved swap bits read nonzero");

    AST_TX_SWAP: assert property (@(posedge clk) disable iff (!resetn)
        pair_pin_swap_bits[0] |-> pin_out.dp[0] == func_out.dm[0] && pin_out.dm[0] == func_out.dp[0])
        else $error("upstream pair not swapped");

    AST_RX_SWAP: assert property (@(posedge clk) disable iff (!resetn)
        ##3 $stable(pair_pin_swap_bits[3]) && !pair_pin_swap_bits[3] |->
        func_in.dp[3] == $past(pin_in.dp[3], 3))
        else $error("downstream receive pair misrouted");

    AST_REMAP_OFF: assert property (@(posedge clk) disable iff (!resetn)
        !remap_mode_enable |-> port_one_logical == 4'h1 && port_two_logical == 4'h2
        && downstream_port_count == 2'h2)
        else $error("identity numbering lost with remap off");

    AST_PORT2_MAP: assert property (@(posedge clk) disable iff (!resetn)
        remap_mode_enable && st_reg.regs.map12[7:4] <= 4'h3 |->
        port_two_logical == st_reg.regs.map12[7:4])
        else $error("port two not mapped from upper nibble");

    AST_ILLEGAL_CODE: assert property (@(posedge clk) disable iff (!resetn)
        remap_mode_enable && st_reg.regs.map12[3:0] > 4'h3 |->
        port_one_logical == 4'h0)
        else $error("illegal port one code not disabled");

    AST_COUNT: assert property (@(posedge clk) disable iff (!resetn)
        remap_mode_enable && port_one_logical == 4'h0 && port_two_logical == 4'h0 |->
        downstream_port_count == 2'h0)
        else $error("port count wrong with both disabled");

    // transmit swap is pure wiring, so these hold in the same cycle
    AST_TX_SWAP_DOWN: assert property (@(posedge clk) disable iff (!resetn)
        pair_pin_swap_bits[3] |->
        pin_out.dp[3] == func_out.dm[3] && pin_out.dm[3] == func_out.dp[3])
        else $error("downstream pair three not swapped");

    AST_TX_PLAIN: assert property (@(posedge clk) disable iff (!resetn)
        !pair_pin_swap_bits[2] |->
        pin_out.dp[2] == func_out.dp[2] && pin_out.dm[2] == func_out.dm[2])
        else $error("unswapped pair two altered");

    AST_PAIR1_FIXED: assert property (@(posedge clk) disable iff (!resetn)
        pin_out.dp[1] == func_out.dp[1] && pin_out.dm[1] == func_out.dm[1])
        else $error("pair one swapped without a control bit");

    // receive side: two sync flops plus the swap flop give three cycles
    AST_RX_SWAPPED: assert property (@(posedge clk) disable iff (!resetn)
        ##3 $stable(pair_pin_swap_bits[0]) && pair_pin_swap_bits[0] |->
        func_in.dp[0] == $past(pin_in.dm[0], 3))
        else $error("upstream receive pair not swapped");

    AST_SWAP_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && cfg_addr == hpcb_pkg::SWAP_ADDR |=>
        pair_pin_swap_bits == ($past(cfg_wdata[3:0]) & 4'hD))
        else $error("swap bits not taken from write");

    AST_BOOST_RESERVED: assert property (@(posedge clk) disable iff (!resetn)
        cfg_rd && cfg_addr == hpcb_pkg::BOOST_ADDR |=>
        cfg_rdata[7:6] == 2'h0 && cfg_rdata[1:0] == 2'h0)
        else $error("reserved boost bits read nonzero");

    AST_MAP_STORE: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr && cfg_addr == hpcb_pkg::MAP12_ADDR |=>
        st_reg.regs.map12 == $past(cfg_wdata))
        else $error("map byte not stored");

    AST_PORT1_MAP: assert property (@(posedge clk) disable iff (!resetn)
        remap_mode_enable && st_reg.regs.map12[3:0] <= 4'h3 |->
        port_one_logical == st_reg.regs.map12[3:0])
        else $error("port one not mapped from lower nibble");

    AST_PORT2_ILLEGAL: assert property (@(posedge clk) disable iff (!resetn)
        remap_mode_enable && st_reg.regs.map12[7:4] > 4'h3 |->
        port_two_logical == 4'h0)
        else $error("illegal port two code not disabled");

    // the count must track live ports whatever codes produced them
    AST_COUNT_TWO: assert property (@(posedge clk) disable iff (!resetn)
        port_one_logical != 4'h0 && port_two_logical != 4'h0 |->
        downstream_port_count == 2'h2)
        else $error("port count wrong with both live");

    AST_COUNT_ONE: assert property (@(posedge clk) disable iff (!resetn)
        (port_one_logical == 4'h0) != (port_two_logical == 4'h0) |->
        downstream_port_count == 2'h1)
        else $error("port count wrong with one live");
endmodule
`default_nettype wire

// [tb/hpcb_far_end.sv]
`timescale 1ns/10ps
`default_nettype none
module hpcb_far_end (
    input wire hpcb_pkg::hpcb_pair_s pin_out,
    input wire logic [3:0] pin_oe,
    input wire hpcb_pkg::hpcb_pair_s tx,
    output var hpcb_pkg::hpcb_pair_s pin_in,
    output var hpcb_pkg::hpcb_pair_s rx
);
    // released pairs read low: far-end pull-downs hold idle lines
    assign rx.dp = pin_out.dp & pin_oe;
    assign rx.dm = pin_out.dm & pin_oe;
    assign pin_in = tx;
endmodule
`default_nettype wire

// [tb/hpcb_port_config_test.sv]
`timescale 1ns/10ps
`default_nettype none
module hpcb_port_config_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic remap_mode_enable = 1'b0;
    logic [3:0] func_oe = 4'hF;
    hpcb_pkg::hpcb_pair_s func_out = 8'hA5;
    hpcb_pkg::hpcb_pair_s tx = 8'hC3;
    wire hpcb_pkg::hpcb_pair_s pin_out, pin_in, func_in, rx;
    wire logic [1:0] lv3, lv2;
    wire logic [7:0] cfg_rdata;
    wire logic [3:0] p1, p2, swp, pin_oe;
    wire logic [1:0] cnt;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    // legal, contiguous maps; port 3 is taken to hold the remaining number
    logic [7:0] mc [6] = '{8'h12, 8'h32, 8'h23, 8'h10, 8'h01, 8'h00};
    logic [11:0] me [6] = '{12'h122, 12'h322, 12'h232, 12'h101, 12'h011, 12'h000};
    hpcb_port_config hpcb_port_config_inst (.clk(clk), .resetn(resetn), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .remap_mode_enable(remap_mode_enable), .port_three_drive_level(lv3),
        .port_two_drive_level(lv2), .pair_pin_swap_bits(swp), .port_one_logical(p1),
        .port_two_logical(p2), .downstream_port_count(cnt), .func_out(func_out),
        .func_oe(func_oe), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .func_in(func_in));
    hpcb_far_end hpcb_far_end_inst (.pin_out(pin_out), .pin_oe(pin_oe), .tx(tx),
        .pin_in(pin_in), .rx(rx));
    initial forever #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // about 130 cycles expected; ceiling far above that
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        @(posedge clk);
        #1;
        chk(cfg_rdata, exp);
    endtask
    // per-bit exchange of the dp and dm nibbles
    function automatic logic [7:0] sw(input logic [7:0] p, input logic [3:0] s);
        return {(p[3:0] & s) | (p[7:4] & ~s), (p[7:4] & s) | (p[3:0] & ~s)};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(8'hF0, 8'h00);
        rd(8'hF1, 8'h00);
        rd(8'hF2, 8'h21);
        wr(8'hF3, 8'hFF);
        rd(8'hF3, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'hC3 | 8'(i << 4) | 8'((3 - i) << 2);
            wr(8'hF0, d);
            chk({6'h00, lv3}, 8'(i));
            chk({6'h00, lv2}, 8'(3 - i));
            rd(8'hF0, d & 8'h3C);
        end
        wr(8'hF0, 8'h00);
        for (int i = 0; i < 2; i++) begin
            d = i ? 8'hFF : 8'h00;
            wr(8'hF1, d);
            rd(8'hF1, d & 8'h0D);
            chk({4'h0, swp}, d & 8'h0D);
            chk(rx, sw(func_out, d[3:0] & 4'hD));
            @(posedge clk);
            tx <= i ? 8'h3C : 8'h96;
            func_oe <= 4'h5;
            repeat (4) @(posedge clk);
            #1;
            chk(func_in, sw(tx, d[3:0] & 4'hD));
            chk(rx, sw(func_out, d[3:0] & 4'hD) & 8'h55);
            chk({4'h0, pin_oe}, 8'h05);
            @(posedge clk);
            func_oe <= 4'hF;
        end
        @(posedge clk);
        remap_mode_enable <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(8'hF2, mc[i]);
            chk({p2, p1}, me[i][11:4]);
            chk({6'h00, cnt}, {4'h0, me[i][3:0]});
            rd(8'hF2, mc[i]);
        end
        // deliberate misuse: illegal codes must not alias a live port
        wr(8'hF2, 8'h4F);
        chk({p2, p1}, 8'h00);
        chk({6'h00, cnt}, 8'h00);
        rd(8'hF2, 8'h4F);
        @(posedge clk);
        remap_mode_enable <= 1'b0;
        @(posedge clk);
        #1;
        chk({p2, p1}, 8'h21);
        chk({6'h00, cnt}, 8'h02);
        // mid-run reset: every byte and the receive path return to idle
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        #1;
        chk(func_in, 8'h00);
        chk({4'h0, swp}, 8'h00);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(8'hF0, 8'h00);
        rd(8'hF1, 8'h00);
        rd(8'hF2, 8'h21);
        complete_run();
    end
endmodule
`default_nettype wire
